// ===== design/block_byte_assembler.sv
`default_nettype none
module block_byte_assembler #(
  parameter int MAX_BYTES = 6
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic restart,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic [MAX_BYTES*8-1:0] value,
  output logic [$clog2(MAX_BYTES+1)-1:0] count
);
  localparam int CW = $clog2(MAX_BYTES + 1);

  if (MAX_BYTES < 1) begin : g_bad_bytes
    $error("block_byte_assembler needs at least one byte");
  end

  // first byte on the bus fills bits 7:0, each later one the next lane up
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= '0;
      count <= '0;
    end else if (clk_en) begin
      if (restart) begin
        value <= '0;
        count <= '0;
      end else if (byte_valid && (int'(count) < MAX_BYTES)) begin
        value[count*8 +: 8] <= byte_data;
        count <= count + CW'(1);
      end
    end
  end
endmodule : block_byte_assembler
`default_nettype wire

// ===== design/hold_timer.sv
`default_nettype none
module hold_timer #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic run,
  output logic expired
);
  logic [WIDTH-1:0] remaining;

  if (WIDTH < 1) begin : g_bad_width
    $error("hold_timer width must be positive");
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      remaining <= '0;
    end else if (clk_en) begin
      if (load) begin
        remaining <= load_value;
      end else if (run && (remaining != '0)) begin
        remaining <= remaining - WIDTH'(1);
      end
    end
  end

  assign expired = (remaining == '0);
endmodule : hold_timer
`default_nettype wire

// ===== design/pmbus_op_pkg.sv
`default_nettype none
package pmbus_op_pkg;
  localparam logic [7:0] OPERATION_CODE = 8'h01;
  localparam logic [7:0] OPERATION_RESET = 8'h00;
  localparam int ON_BIT = 7;
  localparam int PROFILE_BIT = 6;
  localparam int MARGIN_MSB = 5;
  localparam int MARGIN_LSB = 2;
  localparam int BYTE_W = 8;
  localparam int BLOCK_BYTES = 6;
  localparam int HOLD_W = 16;
  localparam logic [3:0] MARGIN_OFF0 = 4'h0;
  localparam logic [3:0] MARGIN_OFF1 = 4'h1;
  localparam logic [3:0] MARGIN_OFF2 = 4'h2;
  localparam logic [3:0] MARGIN_LOW_IGN = 4'h5;
  localparam logic [3:0] MARGIN_LOW_ACT = 4'h6;
  localparam logic [3:0] MARGIN_HIGH_IGN = 4'h9;
  localparam logic [3:0] MARGIN_HIGH_ACT = 4'ha;

  typedef enum logic [1:0] {
    TARGET_NOMINAL = 2'h0,
    TARGET_LOW = 2'h1,
    TARGET_HIGH = 2'h2
  } target_sel_type;

  // gray order along off -> run -> hold -> ramp -> off
  typedef enum logic [1:0] {
    CONV_OFF = 2'h0,
    CONV_RUN = 2'h1,
    CONV_HOLD = 2'h3,
    CONV_RAMP = 2'h2
  } conv_state_type;
endpackage : pmbus_op_pkg
`default_nettype wire

// ===== design/pmbus_operation_command.sv
`default_nettype none
module pmbus_operation_command #(
  parameter int BLOCK_BYTES = pmbus_op_pkg::BLOCK_BYTES,
  parameter int HOLD_W = pmbus_op_pkg::HOLD_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic txn_start,
  input wire logic [7:0] txn_code,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic txn_end,
  input wire logic rd_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic clear_faults,
  input wire logic power_up_policy_bit,
  input wire logic cmd_source_sel,
  input wire logic pin_source_sel,
  input wire logic pin_active_high,
  input wire logic pin_immediate_off,
  input wire logic control_pin,
  input wire logic inputs_ok,
  input wire logic [HOLD_W-1:0] turnoff_hold_time,
  input wire logic vout_at_zero,
  output logic conversion_on,
  output logic stage_hiz,
  output logic ramp_down,
  output pmbus_op_pkg::target_sel_type target_sel,
  output logic ov_uv_ignore,
  output logic unsupported_data,
  output logic alert_n,
  output logic [BLOCK_BYTES*8-1:0] block_value,
  output logic [$clog2(BLOCK_BYTES+1)-1:0] block_len,
  output logic block_done
);
  localparam int CW = $clog2(BLOCK_BYTES + 1);

  if (BLOCK_BYTES < 1 || HOLD_W < 1) begin : g_bad_params
    $error("pmbus_operation_command: bad parameter");
  end

  ////////////////////////////////////////////////////////////////////////////
  // transaction capture

  logic [7:0] code_q;
  logic [7:0] operation_control;
  logic [3:0] wr_margin;
  logic op_txn;
  logic margin_valid;
  logic good_write;
  logic bad_write;
  logic [CW-1:0] byte_count;
  logic [BLOCK_BYTES*8-1:0] byte_value;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= 8'h00;
    end else if (clk_en && txn_start) begin
      code_q <= txn_code;
    end
  end

  block_byte_assembler #(
    .MAX_BYTES(BLOCK_BYTES)
  ) u_assembler (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .restart(txn_start),
    .byte_valid(wr_valid),
    .byte_data(wr_data),
    .value(byte_value),
    .count(byte_count)
  );

  assign op_txn = (code_q == pmbus_op_pkg::OPERATION_CODE);
  assign wr_margin = byte_value[pmbus_op_pkg::MARGIN_MSB:pmbus_op_pkg::MARGIN_LSB];

  always_comb begin
    case (wr_margin)
      pmbus_op_pkg::MARGIN_OFF0, pmbus_op_pkg::MARGIN_OFF1, pmbus_op_pkg::MARGIN_OFF2,
      pmbus_op_pkg::MARGIN_LOW_IGN, pmbus_op_pkg::MARGIN_LOW_ACT,
      pmbus_op_pkg::MARGIN_HIGH_IGN, pmbus_op_pkg::MARGIN_HIGH_ACT: margin_valid = 1'b1;
      default: margin_valid = 1'b0;
    endcase
  end

  // a write byte carries exactly one data byte
  assign good_write = txn_end && op_txn && (byte_count == CW'(1)) && margin_valid;
  assign bad_write = txn_end && op_txn && !((byte_count == CW'(1)) && margin_valid);

  ////////////////////////////////////////////////////////////////////////////
  // operation control register

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      operation_control <= pmbus_op_pkg::OPERATION_RESET;
    end else if (clk_en && good_write) begin
      // low two bits are read-only zero
      operation_control <= {byte_value[7:2], 2'b00};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= rd_req && op_txn;
      rd_data <= operation_control;
    end
  end

  // other codes are handed on as little-endian blocks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_value <= '0;
      block_len <= '0;
      block_done <= 1'b0;
    end else if (clk_en) begin
      block_done <= txn_end && !op_txn;
      if (txn_end && !op_txn) begin
        block_value <= byte_value;
        block_len <= byte_count;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unsupported data status and alert

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      unsupported_data <= 1'b0;
    end else if (clk_en) begin
      // a new bad write wins over a clear in the same cycle
      if (bad_write) begin
        unsupported_data <= 1'b1;
      end else if (clear_faults) begin
        unsupported_data <= 1'b0;
      end
    end
  end

  assign alert_n = !unsupported_data;

  ////////////////////////////////////////////////////////////////////////////
  // enable sources and conversion sequencing

  logic on_bit;
  logic pin_on;
  logic want_on;
  logic cmd_off;
  logic soft_profile;
  logic hold_expired;
  pmbus_op_pkg::conv_state_type conv_state;
  pmbus_op_pkg::conv_state_type next_conv_state;

  assign on_bit = operation_control[pmbus_op_pkg::ON_BIT];
  assign pin_on = pin_active_high ? control_pin : !control_pin;
  // selected sources must all agree; policy 0 runs on input power alone
  assign want_on = !power_up_policy_bit
    || ((!cmd_source_sel || on_bit) && (!pin_source_sel || pin_on));
  assign cmd_off = power_up_policy_bit && cmd_source_sel && !on_bit;
  // profile is read at the off edge, so bit 6 while on has no effect
  assign soft_profile = cmd_off ? operation_control[pmbus_op_pkg::PROFILE_BIT]
                                : !pin_immediate_off;

  always_comb begin
    next_conv_state = conv_state;
    case (conv_state)
      pmbus_op_pkg::CONV_OFF: begin
        if (want_on && inputs_ok) begin
          next_conv_state = pmbus_op_pkg::CONV_RUN;
        end
      end
      pmbus_op_pkg::CONV_RUN: begin
        if (!inputs_ok) begin
          next_conv_state = pmbus_op_pkg::CONV_OFF;
        end else if (!want_on) begin
          next_conv_state = soft_profile ? pmbus_op_pkg::CONV_HOLD
                                         : pmbus_op_pkg::CONV_OFF;
        end
      end
      pmbus_op_pkg::CONV_HOLD: begin
        if (!inputs_ok) begin
          next_conv_state = pmbus_op_pkg::CONV_OFF;
        end else if (want_on) begin
          next_conv_state = pmbus_op_pkg::CONV_RUN;
        end else if (hold_expired) begin
          next_conv_state = pmbus_op_pkg::CONV_RAMP;
        end
      end
      pmbus_op_pkg::CONV_RAMP: begin
        if (vout_at_zero || !inputs_ok) begin
          next_conv_state = pmbus_op_pkg::CONV_OFF;
        end
      end
      default: next_conv_state = pmbus_op_pkg::CONV_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_state <= pmbus_op_pkg::CONV_OFF;
    end else if (clk_en) begin
      conv_state <= next_conv_state;
    end
  end

  hold_timer #(
    .WIDTH(HOLD_W)
  ) u_hold (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .load(conv_state == pmbus_op_pkg::CONV_RUN),
    .load_value(turnoff_hold_time),
    .run(conv_state == pmbus_op_pkg::CONV_HOLD),
    .expired(hold_expired)
  );

  assign conversion_on = (conv_state != pmbus_op_pkg::CONV_OFF);
  assign stage_hiz = (conv_state == pmbus_op_pkg::CONV_OFF);
  assign ramp_down = (conv_state == pmbus_op_pkg::CONV_RAMP);

  ////////////////////////////////////////////////////////////////////////////
  // margin target and fault handling

  logic [3:0] margin;
  assign margin = operation_control[pmbus_op_pkg::MARGIN_MSB:pmbus_op_pkg::MARGIN_LSB];

  always_comb begin
    case (margin)
      pmbus_op_pkg::MARGIN_LOW_IGN, pmbus_op_pkg::MARGIN_LOW_ACT: begin
        target_sel = pmbus_op_pkg::TARGET_LOW;
      end
      pmbus_op_pkg::MARGIN_HIGH_IGN, pmbus_op_pkg::MARGIN_HIGH_ACT: begin
        target_sel = pmbus_op_pkg::TARGET_HIGH;
      end
      default: target_sel = pmbus_op_pkg::TARGET_NOMINAL;
    endcase
  end

  assign ov_uv_ignore = on_bit && ((margin == pmbus_op_pkg::MARGIN_LOW_IGN)
                                || (margin == pmbus_op_pkg::MARGIN_HIGH_IGN));

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence soft_off_begins;
    clk_en && conv_state == pmbus_op_pkg::CONV_RUN && inputs_ok && !want_on && soft_profile;
  endsequence

  sequence hold_done;
    clk_en && conv_state == pmbus_op_pkg::CONV_HOLD && inputs_ok && !want_on && hold_expired;
  endsequence

  low_bits_zero_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n) operation_control[1:0] == 2'b00)
    else $error("read-only low bits not zero");

  good_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && good_write |=> operation_control == {$past(byte_value[7:2]), 2'b00})
    else $error("valid write not applied");

  bad_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && bad_write |=> unsupported_data && !alert_n && $stable(operation_control))
    else $error("unsupported write not flagged or was stored");

  read_back_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && rd_req && op_txn |=> rd_valid && rd_data == $past(operation_control))
    else $error("read back wrong");

  immediate_off_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && conv_state == pmbus_op_pkg::CONV_RUN && cmd_off && !operation_control[6]
    |=> stage_hiz && !conversion_on)
    else $error("immediate off did not reach high-Z");

  soft_off_path_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    soft_off_begins |=> conversion_on && !ramp_down)
    else $error("soft off did not hold regulation");

  ramp_start_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n) hold_done |=> ramp_down && conversion_on)
    else $error("ramp did not follow hold");

  start_gated_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(conversion_on) |-> $past(inputs_ok) && $past(want_on))
    else $error("conversion started without enables");

  fault_ignore_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ov_uv_ignore |-> on_bit && target_sel != pmbus_op_pkg::TARGET_NOMINAL)
    else $error("faults ignored outside ignoring margin");

  act_low_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    margin == pmbus_op_pkg::MARGIN_LOW_ACT |-> target_sel == pmbus_op_pkg::TARGET_LOW
    && !ov_uv_ignore)
    else $error("low margin act-on-fault wrong");

  act_high_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    margin == pmbus_op_pkg::MARGIN_HIGH_ACT |-> target_sel == pmbus_op_pkg::TARGET_HIGH
    && !ov_uv_ignore)
    else $error("high margin act-on-fault wrong");

  free_run_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && !power_up_policy_bit && inputs_ok && stage_hiz |=> conversion_on)
    else $error("policy 0 did not start on input power");
endmodule : pmbus_operation_command
`default_nettype wire

// ===== verification/pmbus_host_model.sv
`default_nettype none
module pmbus_host_model (
  input wire logic sys_clk,
  output logic txn_start,
  output logic [7:0] txn_code,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic txn_end,
  output logic rd_req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    txn_start = 1'b0;
    txn_code = 8'h00;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    txn_end = 1'b0;
    rd_req = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // write transaction: code, then bytes in sending order, then stop
  task automatic write_txn(input logic [7:0] code, input logic [7:0] bytes[$]);
    @(negedge sys_clk);
    txn_start = 1'b1;
    txn_code = code;
    @(negedge sys_clk);
    txn_start = 1'b0;
    txn_code = ~code;
    foreach (bytes[i]) begin
      wr_valid = 1'b1;
      wr_data = bytes[i];
      @(negedge sys_clk);
    end
    // released data line must not keep showing the last byte
    wr_valid = 1'b0;
    wr_data = ~wr_data;
    txn_end = 1'b1;
    @(negedge sys_clk);
    txn_end = 1'b0;
  endtask : write_txn

  //////////////////////////////////////////////////////////////////////////////
  // read transaction: code, then one read byte request
  task automatic read_txn(input logic [7:0] code, output logic [7:0] data,
                          output logic got);
    @(negedge sys_clk);
    txn_start = 1'b1;
    txn_code = code;
    @(negedge sys_clk);
    txn_start = 1'b0;
    txn_code = ~code;
    rd_req = 1'b1;
    @(negedge sys_clk);
    rd_req = 1'b0;
    got = rd_valid;
    data = rd_data;
  endtask : read_txn
endmodule : pmbus_host_model
`default_nettype wire

// ===== verification/pmbus_operation_command_tb.sv
`default_nettype none
module pmbus_operation_command_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic clear_faults = 1'b0;
  logic power_up_policy_bit = 1'b1;
  logic cmd_source_sel = 1'b1;
  logic pin_source_sel = 1'b0;
  logic pin_active_high = 1'b1;
  logic pin_immediate_off = 1'b1;
  logic control_pin = 1'b0;
  logic inputs_ok = 1'b0;
  logic [15:0] turnoff_hold_time = 16'h0003;
  logic vout_at_zero = 1'b0;
  logic txn_start, wr_valid, txn_end, rd_req, rd_valid;
  logic [7:0] txn_code, wr_data, rd_data;
  logic conversion_on, stage_hiz, ramp_down, ov_uv_ignore, unsupported_data, alert_n;
  logic block_done;
  pmbus_op_pkg::target_sel_type target_sel;
  logic [47:0] block_value;
  logic [2:0] block_len;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  always #20 sys_clk = ~sys_clk;

  pmbus_host_model u_host (.sys_clk(sys_clk), .txn_start(txn_start), .txn_code(txn_code),
    .wr_valid(wr_valid), .wr_data(wr_data), .txn_end(txn_end), .rd_req(rd_req),
    .rd_data(rd_data), .rd_valid(rd_valid));

  pmbus_operation_command #(.BLOCK_BYTES(6), .HOLD_W(16)) u_dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .clk_en(clk_en), .txn_start(txn_start), .txn_code(txn_code),
    .wr_valid(wr_valid), .wr_data(wr_data), .txn_end(txn_end), .rd_req(rd_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .clear_faults(clear_faults),
    .power_up_policy_bit(power_up_policy_bit), .cmd_source_sel(cmd_source_sel),
    .pin_source_sel(pin_source_sel), .pin_active_high(pin_active_high),
    .pin_immediate_off(pin_immediate_off), .control_pin(control_pin),
    .inputs_ok(inputs_ok), .turnoff_hold_time(turnoff_hold_time),
    .vout_at_zero(vout_at_zero), .conversion_on(conversion_on), .stage_hiz(stage_hiz),
    .ramp_down(ramp_down), .target_sel(target_sel), .ov_uv_ignore(ov_uv_ignore),
    .unsupported_data(unsupported_data), .alert_n(alert_n), .block_value(block_value),
    .block_len(block_len), .block_done(block_done));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_cyc

  task automatic rd_op(input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    u_host.read_txn(pmbus_op_pkg::OPERATION_CODE, d, v);
    chk("rd_valid", 1'b1, v);
    chk("rd_data", exp, d);
  endtask : rd_op

  task automatic clear_flag;
    clear_faults = 1'b1;
    wait_cyc(1);
    clear_faults = 1'b0;
    chk("unsupported_data", 1'b0, unsupported_data);
    chk("alert_n", 1'b1, alert_n);
  endtask : clear_flag

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("stage_hiz", 1'b1, stage_hiz);
    chk("conversion_on", 1'b0, conversion_on);
    chk("alert_n", 1'b1, alert_n);
    chk("target_sel", pmbus_op_pkg::TARGET_NOMINAL, target_sel);
    rd_op(8'h00);
  endtask : t_reset

  task automatic t_margin;
    logic [3:0] code [7] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha};
    logic [1:0] tgt [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    logic ign [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 7; i++) begin
      u_host.write_txn(8'h01, '{{2'b10, code[i], 2'b11}});
      rd_op({2'b10, code[i], 2'b00});
      chk("target_sel", tgt[i], target_sel);
      chk("ov_uv_ignore", ign[i], ov_uv_ignore);
    end
    // low margin, faults ignored only while on bit set
    u_host.write_txn(8'h01, '{8'h14});
    chk("ov_uv_ignore", 1'b0, ov_uv_ignore);
    chk("target_sel", pmbus_op_pkg::TARGET_LOW, target_sel);
  endtask : t_margin

  task automatic t_unsupported;
    logic [7:0] d;
    logic v;
    u_host.write_txn(8'h01, '{8'h0c});
    chk("unsupported_data", 1'b1, unsupported_data);
    chk("alert_n", 1'b0, alert_n);
    rd_op(8'h14);
    clear_flag();
    u_host.write_txn(8'h01, '{8'h00, 8'h00});
    chk("unsupported_data", 1'b1, unsupported_data);
    rd_op(8'h14);
    clear_flag();
    u_host.read_txn(8'h30, d, v);
    chk("rd_valid", 1'b0, v);
  endtask : t_unsupported

  task automatic t_convert;
    inputs_ok = 1'b1;
    u_host.write_txn(8'h01, '{8'h80});
    wait_cyc(1);
    chk("conversion_on", 1'b1, conversion_on);
    inputs_ok = 1'b0;
    wait_cyc(1);
    chk("conversion_on", 1'b0, conversion_on);
    inputs_ok = 1'b1;
    wait_cyc(1);
    chk("conversion_on", 1'b1, conversion_on);
    u_host.write_txn(8'h01, '{8'h00});
    wait_cyc(1);
    chk("stage_hiz", 1'b1, stage_hiz);
    chk("ramp_down", 1'b0, ramp_down);
    u_host.write_txn(8'h01, '{8'hc0});
    u_host.write_txn(8'h01, '{8'h80});
    chk("conversion_on", 1'b1, conversion_on);
    u_host.write_txn(8'h01, '{8'h40});
    wait_cyc(1);
    chk("conversion_on", 1'b1, conversion_on);
    wait_cyc(3);
    chk("ramp_down", 1'b0, ramp_down);
    wait_cyc(1);
    chk("ramp_down", 1'b1, ramp_down);
    vout_at_zero = 1'b1;
    wait_cyc(1);
    chk("stage_hiz", 1'b1, stage_hiz);
    vout_at_zero = 1'b0;
  endtask : t_convert

  task automatic t_sources;
    cmd_source_sel = 1'b0;
    wait_cyc(1);
    chk("conversion_on", 1'b1, conversion_on);
    pin_source_sel = 1'b1;
    wait_cyc(1);
    chk("stage_hiz", 1'b1, stage_hiz);
    control_pin = 1'b1;
    wait_cyc(1);
    chk("conversion_on", 1'b1, conversion_on);
    pin_active_high = 1'b0;
    wait_cyc(1);
    chk("stage_hiz", 1'b1, stage_hiz);
    // pin turn-off with the soft profile: hold, then ramp
    pin_active_high = 1'b1;
    wait_cyc(1);
    chk("conversion_on", 1'b1, conversion_on);
    pin_immediate_off = 1'b0;
    control_pin = 1'b0;
    wait_cyc(1);
    chk("conversion_on", 1'b1, conversion_on);
    chk("ramp_down", 1'b0, ramp_down);
    wait_cyc(4);
    chk("ramp_down", 1'b1, ramp_down);
    vout_at_zero = 1'b1;
    wait_cyc(1);
    chk("stage_hiz", 1'b1, stage_hiz);
    vout_at_zero = 1'b0;
    pin_immediate_off = 1'b1;
    power_up_policy_bit = 1'b0;
    wait_cyc(1);
    chk("conversion_on", 1'b1, conversion_on);
    // clock enable low freezes the state even when the enables drop
    clk_en = 1'b0;
    inputs_ok = 1'b0;
    wait_cyc(2);
    chk("conversion_on", 1'b1, conversion_on);
    clk_en = 1'b1;
    wait_cyc(1);
    chk("conversion_on", 1'b0, conversion_on);
    inputs_ok = 1'b1;
    power_up_policy_bit = 1'b1;
    cmd_source_sel = 1'b1;
    pin_source_sel = 1'b0;
  endtask : t_sources

  task automatic t_block;
    u_host.write_txn(8'h30, '{8'h11, 8'h22, 8'h33});
    chk("block_done", 1'b1, block_done);
    chk("block_len", 3'h3, block_len);
    chk("block_value", 24'h33_2211, block_value[23:0]);
    u_host.write_txn(8'h30, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07});
    chk("block_len", 3'h6, block_len);
    chk("block_value", 48'h0605_0403_0201, block_value);
  endtask : t_block

  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    wait_cyc(2);
    rst_n = 1'b1;
    t_reset();
    t_margin();
    t_unsupported();
    t_convert();
    t_sources();
    t_block();
    wrap_up();
  end
endmodule : pmbus_operation_command_tb
`default_nettype wire
